// ### oad_operand_decoder.sv
// Purpose: decode one instruction operand into address, register or value
// Assumes: the datapath has already read the chosen register into reg_data
// Notes: one cycle from request to registered result; i_ce freezes all
//
// How it works
// - byte register 0/1 gives 00H-FFH address
// - bank byte register from 3-bit index 0-7
// - file byte register 4-bit src, dst indices
// - word register index doubles field, 0-30
// - word indirect addresses region 00, 16 bits
// - word indirect adds 16-bit offset in region 00
// - dword indices 0-28 step 4, 56, 60
// - dword indirect reaches whole 24-bit space
// - dword indirect adds offset over 24 bits
// - direct byte goes to memory or SPECIAL_FUNCTION_REGISTER
// - direct wide address reaches memory only
// - byte and word immediates pass to datapath
// - dword immediate fills upper word 0 or 1
// - short immediate code yields 1, 2 or 4
// - extended bit in 20H-7FH or SPECIAL_FUNCTION_REGISTER, bit 0-7
// - legacy bits 00H-7FH map RAM 20H-2FH
// - legacy bits 80H-FFH map SFRs ending 0H/8H
`timescale 1ns/1ps
`default_nettype none

module oad_operand_decoder
  import oad_pkg::*;
(
  input wire logic i_clock,          // core clock, 100 MHz
  input wire logic i_rstn,           // async reset, active low
  input wire logic i_ce,             // clock enable, low freezes state
  input wire logic i_req_valid,      // operand request this cycle
  input var oad_req_t i_req,         // operand fields and register data
  output logic o_res_valid,          // decoded result ready, one pulse
  output oad_res_t o_res             // decoded operand, held until next
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // dword field to register number; codes 8-13 have no register
  function automatic logic [5:0] dw_index(input logic [3:0] f);
    logic [5:0] r;
    r = {f, 2'b00};
    if (f == OAD_DW_CODE_56) begin
      r = OAD_DW_IDX_56;
    end else if (f == OAD_DW_CODE_60) begin
      r = OAD_DW_IDX_60;
    end
    return r;
  endfunction

  function automatic logic dw_legal(input logic [3:0] f);
    return (f <= OAD_DW_LAST_LINEAR) || (f == OAD_DW_CODE_56) ||
           (f == OAD_DW_CODE_60);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // combinational decode

  oad_res_t res_d;
  oad_res_t res_q;
  logic valid_q;
  logic [15:0] word_sum;
  logic [23:0] dword_sum;
  logic [7:0] ext_byte;

  // region 00 wraps inside 64K, so the carry out is dropped on purpose
  assign word_sum = i_req.reg_data[15:0] + i_req.offset[15:0];
  assign dword_sum = i_req.reg_data[23:0] + i_req.offset;
  assign ext_byte = i_req.direct[7:0];

  // one branch per operand form; unused fields stay zero
  always_comb begin
    res_d = '0;
    res_d.kind = i_req.kind;
    case (i_req.kind)
      OAD_BYTE_REG_INDIRECT: begin
        res_d.src_reg = {5'h00, i_req.src_field[0]};
        res_d.addr = {OAD_PAGE_00, i_req.reg_data[7:0]};
      end
      OAD_BANK_BYTE_REG: begin
        res_d.src_reg = {3'h0, i_req.src_field[2:0]};
      end
      OAD_FILE_BYTE_REG: begin
        res_d.src_reg = {2'h0, i_req.src_field};
        res_d.dst_reg = {2'h0, i_req.dst_field};
      end
      OAD_WORD_REG: begin
        res_d.src_reg = {1'b0, i_req.src_field, 1'b0};
        res_d.dst_reg = {1'b0, i_req.dst_field, 1'b0};
      end
      OAD_WORD_REG_INDIRECT: begin
        res_d.src_reg = {1'b0, i_req.src_field, 1'b0};
        res_d.addr = {OAD_REGION_00, i_req.reg_data[15:0]};
      end
      OAD_WORD_REG_INDIRECT_OFS: begin
        res_d.src_reg = {1'b0, i_req.src_field, 1'b0};
        res_d.addr = {OAD_REGION_00, word_sum};
      end
      OAD_DWORD_REG: begin
        res_d.src_reg = dw_index(i_req.src_field);
        res_d.dst_reg = dw_index(i_req.dst_field);
        res_d.illegal = !dw_legal(i_req.src_field) ||
                        !dw_legal(i_req.dst_field);
      end
      OAD_DWORD_REG_INDIRECT: begin
        res_d.src_reg = dw_index(i_req.src_field);
        res_d.addr = i_req.reg_data[23:0];
        res_d.illegal = !dw_legal(i_req.src_field);
      end
      OAD_DWORD_REG_INDIRECT_OFS: begin
        res_d.src_reg = dw_index(i_req.src_field);
        res_d.addr = dword_sum;
        res_d.illegal = !dw_legal(i_req.src_field);
      end
      OAD_DIRECT_BYTE_ADDRESS: begin
        res_d.addr = {OAD_PAGE_00, i_req.direct[7:0]};
        res_d.to_sfr = i_req.sfr_sel;
      end
      OAD_DIRECT_WIDE_ADDRESS: begin
        res_d.addr = {OAD_REGION_00, i_req.direct};
        res_d.to_sfr = 1'b0;
      end
      OAD_IMM_BYTE: begin
        res_d.operand = {OAD_ZERO_DATA, i_req.imm[7:0]};
      end
      OAD_IMM_WORD: begin
        res_d.operand = {OAD_FILL_ZEROS, i_req.imm};
      end
      OAD_IMM_DWORD: begin
        res_d.operand = {i_req.fill_ones ? OAD_FILL_ONES
                                         : OAD_FILL_ZEROS,
                         i_req.imm};
      end
      OAD_IMM_SHORT: begin
        // the fourth code has no constant, so it is refused
        case (i_req.short_code)
          OAD_SHORT_CODE_1: res_d.operand = OAD_SHORT_VAL_1;
          OAD_SHORT_CODE_2: res_d.operand = OAD_SHORT_VAL_2;
          OAD_SHORT_CODE_4: res_d.operand = OAD_SHORT_VAL_4;
          default: res_d.illegal = 1'b1;
        endcase
      end
      OAD_EXT_BIT: begin
        res_d.addr = {OAD_PAGE_00, ext_byte};
        res_d.to_sfr = i_req.sfr_sel;
        res_d.bit_pos = i_req.bit_sel;
        // memory bits exist only in the bit-addressable bytes
        res_d.illegal = !i_req.sfr_sel &&
                        ((ext_byte < OAD_EXT_BIT_LO) ||
                         (ext_byte > OAD_EXT_BIT_HI));
      end
      OAD_LEGACY_BIT_OPERAND: begin
        res_d.bit_pos = i_req.direct[2:0];
        if (!i_req.direct[OAD_LEGACY_SFR_MSB]) begin
          res_d.addr = {OAD_PAGE_00,
                        OAD_BIT_RAM_BASE | {4'h0, i_req.direct[6:3]}};
          res_d.to_sfr = 1'b0;
        end else begin
          res_d.addr = {OAD_PAGE_00, i_req.direct[7:3],
                        OAD_SFR_ROW_LOW};
          res_d.to_sfr = 1'b1;
        end
      end
      default: begin
        res_d.illegal = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  // result pulse; one cycle per accepted request
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      valid_q <= 1'b0;
    end else if (i_ce) begin
      valid_q <= i_req_valid;
    end
  end

  // result held until the next request, so the datapath may read late
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      res_q <= '0;
    end else if (i_ce && i_req_valid) begin
      res_q <= res_d;
    end
  end

  assign o_res_valid = valid_q;
  assign o_res = res_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_byte_ind;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_BYTE_REG_INDIRECT |=>
      o_res.addr[23:8] == 16'h0000 &&
      o_res.addr[7:0] == $past(i_req.reg_data[7:0]) &&
      o_res.src_reg == {5'h00, $past(i_req.src_field[0])};
  endproperty
  a_byte_ind: assert property (p_byte_ind)
    else $error("byte indirect address wrong");

  property p_bank_reg;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_BANK_BYTE_REG |=>
      o_res.src_reg == {3'h0, $past(i_req.src_field[2:0])};
  endproperty
  a_bank_reg: assert property (p_bank_reg)
    else $error("bank byte register index wrong");

  property p_word_reg;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_WORD_REG |=>
      o_res.dst_reg == 6'($past(i_req.dst_field) * 2) &&
      o_res.src_reg == 6'($past(i_req.src_field) * 2);
  endproperty
  a_word_reg: assert property (p_word_reg)
    else $error("word register index wrong");

  property p_word_ofs;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_WORD_REG_INDIRECT_OFS |=>
      o_res.addr[23:16] == 8'h00 &&
      o_res.addr[15:0] == 16'($past(i_req.reg_data[15:0]) +
                              $past(i_req.offset[15:0]));
  endproperty
  a_word_ofs: assert property (p_word_ofs)
    else $error("word indirect offset address wrong");

  property p_dword_idx;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_DWORD_REG &&
      i_req.src_field == 4'hF |=> o_res.src_reg == 6'h3C;
  endproperty
  a_dword_idx: assert property (p_dword_idx)
    else $error("dword register 60 not reached");

  property p_dword_bad;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_DWORD_REG_INDIRECT |=>
      o_res.illegal == ($past(i_req.src_field) inside {[4'h8:4'hD]});
  endproperty
  a_dword_bad: assert property (p_dword_bad)
    else $error("dword index legality wrong");

  property p_wide_mem;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_DIRECT_WIDE_ADDRESS |=>
      !o_res.to_sfr && o_res.addr == {8'h00, $past(i_req.direct)};
  endproperty
  a_wide_mem: assert property (p_wide_mem)
    else $error("wide direct address reached SPECIAL_FUNCTION_REGISTER space");

  property p_imm_fill;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_IMM_DWORD |=>
      o_res.operand[31:16] == {16{$past(i_req.fill_ones)}} &&
      o_res.operand[15:0] == $past(i_req.imm);
  endproperty
  a_imm_fill: assert property (p_imm_fill)
    else $error("dword immediate fill wrong");

  property p_short;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_IMM_SHORT &&
      i_req.short_code != 2'h3 |=>
      o_res.operand == (32'h1 << $past(i_req.short_code));
  endproperty
  a_short: assert property (p_short)
    else $error("short immediate value wrong");

  property p_legacy;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_LEGACY_BIT_OPERAND |=>
      (o_res.to_sfr ? (o_res.addr[2:0] == 3'h0 && o_res.addr[7])
                    : (o_res.addr[7:4] == 4'h2)) &&
      o_res.to_sfr == $past(i_req.direct[7]);
  endproperty
  a_legacy: assert property (p_legacy)
    else $error("legacy bit mapping wrong");

  property p_file_reg;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_FILE_BYTE_REG |=>
      o_res.src_reg == {2'h0, $past(i_req.src_field)} &&
      o_res.dst_reg == {2'h0, $past(i_req.dst_field)};
  endproperty
  a_file_reg: assert property (p_file_reg)
    else $error("file byte register index wrong");

  property p_word_ind;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_WORD_REG_INDIRECT |=>
      o_res.addr == {8'h00, $past(i_req.reg_data[15:0])} && !o_res.to_sfr;
  endproperty
  a_word_ind: assert property (p_word_ind)
    else $error("word indirect address left region 00");

  property p_dword_ind;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_DWORD_REG_INDIRECT |=>
      o_res.addr == $past(i_req.reg_data[23:0]);
  endproperty
  a_dword_ind: assert property (p_dword_ind)
    else $error("dword indirect address wrong");

  property p_dword_ofs;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_DWORD_REG_INDIRECT_OFS |=>
      o_res.addr == 24'($past(i_req.reg_data[23:0]) + $past(i_req.offset));
  endproperty
  a_dword_ofs: assert property (p_dword_ofs)
    else $error("dword indirect offset address wrong");

  property p_direct_byte;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_DIRECT_BYTE_ADDRESS |=>
      o_res.addr == {16'h0000, $past(i_req.direct[7:0])} &&
      o_res.to_sfr == $past(i_req.sfr_sel);
  endproperty
  a_direct_byte: assert property (p_direct_byte)
    else $error("direct byte address steered wrong");

  property p_ext_bit;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_EXT_BIT |=>
      o_res.bit_pos == $past(i_req.bit_sel) &&
      o_res.to_sfr == $past(i_req.sfr_sel) &&
      (o_res.illegal || o_res.to_sfr ||
       o_res.addr inside {[24'h000020:24'h00007F]});
  endproperty
  a_ext_bit: assert property (p_ext_bit)
    else $error("extended bit operand out of range");

  property p_legacy_ram;
    @(posedge i_clock) disable iff (!i_rstn)
    i_ce && i_req_valid && i_req.kind == OAD_LEGACY_BIT_OPERAND &&
      !i_req.direct[7] |=>
      o_res.addr == {16'h0000, 4'h2, $past(i_req.direct[6:3])} &&
      o_res.bit_pos == $past(i_req.direct[2:0]);
  endproperty
  a_legacy_ram: assert property (p_legacy_ram)
    else $error("legacy bit not mapped into RAM bytes 20H-2FH");

  property p_hold;
    @(posedge i_clock) disable iff (!i_rstn)
    !i_ce |=> $stable(o_res) && $stable(o_res_valid);
  endproperty
  a_hold: assert property (p_hold)
    else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// ### oad_pkg.sv
// Purpose: shared types and constants for the operand addressing decoder
// Assumes: one core clock; request fields come from same-clock fetch logic
// Notes: every figure used by the decoder logic lives here
package oad_pkg;

  // operand forms presented by instruction fetch
  typedef enum logic [4:0] {
    OAD_BYTE_REG_INDIRECT,
    OAD_BANK_BYTE_REG,
    OAD_FILE_BYTE_REG,
    OAD_WORD_REG,
    OAD_WORD_REG_INDIRECT,
    OAD_WORD_REG_INDIRECT_OFS,
    OAD_DWORD_REG,
    OAD_DWORD_REG_INDIRECT,
    OAD_DWORD_REG_INDIRECT_OFS,
    OAD_DIRECT_BYTE_ADDRESS,
    OAD_DIRECT_WIDE_ADDRESS,
    OAD_IMM_BYTE,
    OAD_IMM_WORD,
    OAD_IMM_DWORD,
    OAD_IMM_SHORT,
    OAD_EXT_BIT,
    OAD_LEGACY_BIT_OPERAND
  } oad_kind_t;

  // widths
  localparam int OAD_ADDR_W = 24;
  localparam int OAD_REG_W = 6;

  // fixed address parts and operand fills
  localparam logic [7:0] OAD_REGION_00 = 8'h00;
  localparam logic [15:0] OAD_PAGE_00 = 16'h0000;
  localparam logic [15:0] OAD_FILL_ONES = 16'hFFFF;
  localparam logic [15:0] OAD_FILL_ZEROS = 16'h0000;
  localparam logic [23:0] OAD_ZERO_DATA = 24'h000000;

  // bit addressable areas
  localparam logic [7:0] OAD_BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] OAD_EXT_BIT_LO = 8'h20;
  localparam logic [7:0] OAD_EXT_BIT_HI = 8'h7F;
  localparam int OAD_LEGACY_SFR_MSB = 7;
  localparam logic [2:0] OAD_SFR_ROW_LOW = 3'h0;

  // dword register index encoding
  localparam logic [3:0] OAD_DW_LAST_LINEAR = 4'h7;
  localparam logic [3:0] OAD_DW_CODE_56 = 4'hE;
  localparam logic [3:0] OAD_DW_CODE_60 = 4'hF;
  localparam logic [5:0] OAD_DW_IDX_56 = 6'h38;
  localparam logic [5:0] OAD_DW_IDX_60 = 6'h3C;

  // short immediate codes and values
  localparam logic [1:0] OAD_SHORT_CODE_1 = 2'h0;
  localparam logic [1:0] OAD_SHORT_CODE_2 = 2'h1;
  localparam logic [1:0] OAD_SHORT_CODE_4 = 2'h2;
  localparam logic [31:0] OAD_SHORT_VAL_1 = 32'h00000001;
  localparam logic [31:0] OAD_SHORT_VAL_2 = 32'h00000002;
  localparam logic [31:0] OAD_SHORT_VAL_4 = 32'h00000004;

  // one operand request from fetch
  typedef struct packed {
    oad_kind_t kind;
    logic [3:0] src_field;     // byte_index_field / dword_index_field
    logic [3:0] dst_field;
    logic [31:0] reg_data;     // contents of the chosen register
    logic [23:0] offset;       // short_offset in low 16 bits, long_offset
    logic [15:0] direct;       // direct_wide_address or byte in low 8
    logic [15:0] imm;          // imm_word, byte in low 8
    logic [1:0] short_code;
    logic [2:0] bit_sel;
    logic sfr_sel;             // byte direct / ext bit aimed at SPECIAL_FUNCTION_REGISTER space
    logic fill_ones;           // imm_dword_one_ext when set
  } oad_req_t;

  // decoded operand for the datapath
  typedef struct packed {
    oad_kind_t kind;
    logic [23:0] addr;
    logic to_sfr;
    logic [5:0] src_reg;
    logic [5:0] dst_reg;
    logic [31:0] operand;
    logic [2:0] bit_pos;
    logic illegal;
  } oad_res_t;

endpackage

// ### oad_datapath_model.sv
// Purpose: datapath stand-in that latches each decoded operand
// Assumes: shares the core clock and clock enable with the decoder
// Notes: takes a result only on an enabled edge, as pipeline regs would
`timescale 1ns/1ps
`default_nettype none

module oad_datapath_model
  import oad_pkg::*;
(
  input wire logic i_clock,      // core clock
  input wire logic i_rstn,       // async reset, active low
  input wire logic i_ce,         // shared clock enable
  input wire logic i_res_valid,  // decoder result strobe
  input var oad_res_t i_res,     // decoder result
  output logic o_took,           // one pulse per operand taken
  output oad_res_t o_took_res    // operand as latched
);
  ////////////////////////////////////////////////////////////
  // a frozen enable must not let one strobe be taken twice
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_took <= 1'b0;
      o_took_res <= '0;
    end else begin
      // a frozen edge leaves no pulse behind, so none is counted twice
      o_took <= i_ce && i_res_valid;
      if (i_ce && i_res_valid) begin
        o_took_res <= i_res;
      end
    end
  end
endmodule

`default_nettype wire

// ### tb.sv
// Purpose: self-checking bench for the operand addressing decoder
// Assumes: a result follows one enabled edge after a taken request
// Notes: fields come from an lfsr; every field of every form is judged
`timescale 1ns/1ps
`default_nettype none

module tb
  import oad_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic i_ce = 1'b1;
  logic i_req_valid = 1'b0;
  oad_req_t i_req = '0;
  logic o_res_valid;
  oad_res_t o_res;
  logic took;
  oad_res_t took_res;
  oad_res_t exp_q[$];
  oad_res_t last = '0;
  logic [31:0] seed = 32'h20E98816;
  int miscompares = 0;
  int cmp_count = 0;

  always #5 i_clock = ~i_clock;

  oad_operand_decoder oad_operand_decoder_i (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_req_valid(i_req_valid), .i_req(i_req),
    .o_res_valid(o_res_valid), .o_res(o_res)
  );

  oad_datapath_model oad_datapath_model_i (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_res_valid(o_res_valid), .i_res(o_res),
    .o_took(took), .o_took_res(took_res)
  );

  ////////////////////////////////////////////////////////////
  // reference model and helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic oad_res_t model(input oad_req_t r);
    oad_res_t e;
    logic [7:0] n;
    e = '0;
    n = r.direct[7:0];
    e.kind = r.kind;
    case (r.kind)
      OAD_BYTE_REG_INDIRECT: begin
        e.addr = {16'h0000, r.reg_data[7:0]};
        e.src_reg = {5'h00, r.src_field[0]};
      end
      OAD_BANK_BYTE_REG: e.src_reg = {3'h0, r.src_field[2:0]};
      OAD_FILE_BYTE_REG: begin
        e.src_reg = {2'h0, r.src_field};
        e.dst_reg = {2'h0, r.dst_field};
      end
      OAD_WORD_REG: begin
        e.src_reg = {1'h0, r.src_field, 1'h0};
        e.dst_reg = {1'h0, r.dst_field, 1'h0};
      end
      OAD_DWORD_REG: begin
        e.src_reg = {r.src_field, 2'h0};
        e.dst_reg = {r.dst_field, 2'h0};
        e.illegal = (r.src_field[3] && r.src_field < 4'hE) ||
                    (r.dst_field[3] && r.dst_field < 4'hE);
      end
      OAD_WORD_REG_INDIRECT: e.addr = {8'h00, r.reg_data[15:0]};
      OAD_WORD_REG_INDIRECT_OFS:
        e.addr = {8'h00, r.reg_data[15:0] + r.offset[15:0]};
      OAD_DWORD_REG_INDIRECT: e.addr = r.reg_data[23:0];
      OAD_DWORD_REG_INDIRECT_OFS: e.addr = r.reg_data[23:0] + r.offset;
      OAD_DIRECT_BYTE_ADDRESS: begin
        e.addr = {16'h0000, n};
        e.to_sfr = r.sfr_sel;
      end
      OAD_DIRECT_WIDE_ADDRESS: e.addr = {8'h00, r.direct};
      OAD_IMM_BYTE: e.operand = {24'h000000, r.imm[7:0]};
      OAD_IMM_WORD: e.operand = {16'h0000, r.imm};
      OAD_IMM_DWORD: e.operand = {r.fill_ones ? 16'hFFFF : 16'h0000, r.imm};
      OAD_IMM_SHORT: begin
        e.illegal = (r.short_code == 2'h3);
        e.operand = e.illegal ? 32'h0 : 32'h1 << r.short_code;
      end
      OAD_EXT_BIT: begin
        e.addr = {16'h0000, n};
        e.to_sfr = r.sfr_sel;
        e.bit_pos = r.bit_sel;
        e.illegal = !r.sfr_sel && (n < 8'h20 || n > 8'h7F);
      end
      default: begin
        e.to_sfr = n[7];
        e.addr[7:0] = n[7] ? {n[7:3], 3'h0} : {4'h2, n[6:3]};
        e.bit_pos = n[2:0];
      end
    endcase
    // indirect forms still report the register they read through
    if (r.kind == OAD_WORD_REG_INDIRECT ||
        r.kind == OAD_WORD_REG_INDIRECT_OFS) begin
      e.src_reg = {1'h0, r.src_field, 1'h0};
    end
    if (r.kind == OAD_DWORD_REG_INDIRECT ||
        r.kind == OAD_DWORD_REG_INDIRECT_OFS) begin
      e.src_reg = {r.src_field, 2'h0};
      e.illegal = r.src_field[3] && r.src_field < 4'hE;
    end
    return e;
  endfunction

  task automatic end_of_test;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic ck(input logic [127:0] seen, input logic [127:0] want,
                    input string what);
    cmp_count++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected %0t: %s got %0h want %0h", $time, what, seen, want);
    end
  endtask

  // every field is judged; fields a form leaves unused must read zero
  task automatic judge(input oad_res_t g, input oad_res_t w);
    ck(g.kind, w.kind, "kind");
    ck(g.addr[7:0], w.addr[7:0], "addr lo");
    ck(g.addr[15:8], w.addr[15:8], "addr mid");
    ck(g.addr[23:16], w.addr[23:16], "addr hi");
    ck(g.to_sfr, w.to_sfr, "sfr");
    ck(g.src_reg, w.src_reg, "src");
    ck(g.dst_reg, w.dst_reg, "dst");
    ck(g.operand, w.operand, "operand");
    ck(g.bit_pos, w.bit_pos, "bit");
    ck(g.illegal, w.illegal, "illegal");
  endtask

  task automatic send(input oad_req_t r);
    @(negedge i_clock);
    i_req_valid = 1'b1;
    i_req = r;
    exp_q.push_back(model(r));
  endtask

  task automatic rand_req(input int k);
    logic [127:0] v;
    oad_req_t r;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v[32*i +: 32] = seed;
    end
    r = v[107:0];
    r.kind = oad_kind_t'(k[4:0]);
    send(r);
  endtask

  task automatic idle_drain;
    int n;
    @(negedge i_clock);
    i_req_valid = 1'b0;
    n = 0;
    while (exp_q.size() != 0 && n < 20) begin
      @(negedge i_clock);
      n++;
    end
    if (exp_q.size() != 0) begin
      $display("unexpected %0t: result missing", $time);
      miscompares++;
      end_of_test;
    end
  endtask

  ////////////////////////////////////////////////////////////
  // results are taken at the datapath; between them o_res must stand
  always @(negedge i_clock) begin
    if (!i_rstn) begin
      last = '0;
    end else begin
      if (took && exp_q.size() == 0) begin
        ck(128'h1, 128'h0, "extra result");
      end else if (took) begin
        last = exp_q.pop_front();
        judge(took_res, last);
      end
      if (!o_res_valid) begin
        judge(o_res, last);
      end
    end
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge i_clock);
    $display("unexpected %0t: run hung", $time);
    miscompares++;
    end_of_test;
  end

  initial begin
    oad_req_t r;
    repeat (3) @(negedge i_clock);
    i_rstn = 1'b1;
    // every form back to back with random fields
    for (int p = 0; p < 30; p++) begin
      for (int k = 0; k < 17; k++) begin
        rand_req(k);
      end
    end
    // dword codes, short codes and bit range edges
    for (int v = 0; v < 16; v++) begin
      r = '0;
      r.src_field = v[3:0];
      r.dst_field = ~v[3:0];
      r.short_code = v[1:0];
      r.direct = 16'h0078 + 16'(v);
      r.kind = OAD_DWORD_REG;
      send(r);
      r.kind = OAD_IMM_SHORT;
      send(r);
      r.kind = OAD_LEGACY_BIT_OPERAND;
      send(r);
      r.kind = OAD_EXT_BIT;
      send(r);
      r.direct = 16'h0018 + 16'(v);
      send(r);
    end
    // offsets wrap within their space
    r = '0;
    r.kind = OAD_WORD_REG_INDIRECT_OFS;
    r.reg_data = 32'h00FFFFFF;
    r.offset = 24'h000001;
    send(r);
    r.kind = OAD_DWORD_REG_INDIRECT_OFS;
    send(r);
    idle_drain();
    // a standing result freezes and a request with the enable low is
    // ignored; the result is still taken once when the enable returns
    rand_req(5);
    @(negedge i_clock);
    i_ce = 1'b0;
    i_req_valid = 1'b1;
    repeat (4) @(negedge i_clock);
    i_req_valid = 1'b0;
    i_ce = 1'b1;
    repeat (4) @(negedge i_clock);
    // reset in mid-run clears the result
    i_rstn = 1'b0;
    repeat (2) @(negedge i_clock);
    i_rstn = 1'b1;
    rand_req(13);
    idle_drain();
    end_of_test;
  end
endmodule

`default_nettype wire
